//--- verilog/xda_pkg.sv
package xda_pkg;

  // core clock and machine cycle
  localparam int unsigned CLK_FREQ_MHZ  = 250;
  localparam int unsigned CLK_PERIOD_NS = 1000 / CLK_FREQ_MHZ;
  localparam int unsigned MC_CLKS       = 4;
  localparam int unsigned PH_W          = 2;

  // register byte offsets
  localparam int unsigned ADDR_W        = 12;
  localparam logic [11:0] OFF_CLK_CTRL  = 12'h000;
  localparam logic [11:0] OFF_MEM_MAP   = 12'h004;
  localparam logic [11:0] OFF_TA_KEY    = 12'h008;
  localparam logic [11:0] OFF_DPTR0     = 12'h00C;
  localparam logic [11:0] OFF_DPTR1     = 12'h010;
  localparam logic [11:0] OFF_DP_SEL    = 12'h014;
  localparam logic [11:0] OFF_WORK_REG  = 12'h018;
  localparam logic [11:0] OFF_PORT_TWO  = 12'h01C;
  localparam logic [11:0] OFF_MOVE_CMD  = 12'h020;
  localparam logic [11:0] OFF_STATUS    = 12'h024;

  // field positions
  localparam int unsigned WAIT_EN_BIT   = 7;
  localparam int unsigned CMD_DIR_BIT   = 0;
  localparam int unsigned CMD_MODE_BIT  = 1;
  localparam int unsigned CMD_DATA_LSB  = 8;

  // reset values
  localparam logic [2:0]  STRETCH_RST   = 3'h1;
  localparam logic        WAIT_EN_RST   = 1'b0;
  localparam logic [15:0] DATA_POINTER_RST      = 16'h0000;
  localparam logic [7:0]  BYTE_RST      = 8'h00;
  localparam logic [31:0] WORD_RST      = 32'h0000_0000;

  // timed access keys and open window in clocks
  localparam logic [7:0]  TA_KEY1       = 8'hAA;
  localparam logic [7:0]  TA_KEY2       = 8'h55;
  localparam logic [3:0]  TA_WIN_CLKS   = 4'hC;

  typedef enum logic [2:0] {
    st_idle   = 3'b001,
    st_fetch  = 3'b010,
    st_access = 3'b100
  } xda_state_t;

endpackage : xda_pkg

//--- verilog/xda_phase_gen.sv
`timescale 1ns/100ps
module xda_phase_gen
  import xda_pkg::*;
#(
  parameter int unsigned CLKS = MC_CLKS
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  output logic      [PH_W-1:0] phase,
  output logic                 cyc_last
);

  localparam logic [PH_W-1:0] LAST_PH = PH_W'(CLKS - 1);

  logic [PH_W-1:0] phase_r;
  logic [PH_W-1:0] phase_nxt;

  // free running so every move starts on a machine cycle boundary
  assign phase_nxt = (phase_r == LAST_PH) ? '0 : phase_r + 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= '0;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  assign phase    = phase_r;
  assign cyc_last = (phase_r == LAST_PH);

endmodule : xda_phase_gen

//--- verilog/xda_ext_move.sv
// Summary of operation
// - fetch cycle first, access cycle follows
// - three bit stretch select, strobe width scales
// - move lasts stretch plus two cycles
// - stretch lengthens only external moves
// - stretch resets to one
// - wait pin honoured only when enabled
// - stretch sets minimum, wait adds cycles
// - wait sampled at clock state three
// - each asserted sample adds one cycle
// - unlimited waits, ends when wait released
// - wait enable written only via timed access
// - use zero stretch with wait enabled
// - pointer move drives selected sixteen bit pointer
// - indexed move uses work reg and port two
`timescale 1ns/100ps
module xda_ext_move
  import xda_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic      [15:0]       ext_addr,
  output logic      [7:0]        ext_wdata,
  output logic                   ext_data_oe,
  input  wire logic [7:0]        ext_rdata,
  output logic                   rd_n,
  output logic                   wr_n,
  input  wire logic              port_four_bit_zero_n,
  output logic                   move_busy,
  output logic                   move_done
);

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    return a == off;
  endfunction : hit

  // phase at which the strobe opens in the first access cycle
  function automatic logic [PH_W-1:0] st_ph(input logic [2:0] s);
    return (s == 3'h0) ? 2'h1 : 2'h2;
  endfunction : st_ph

  // phase at which the strobe closes in the final access cycle
  function automatic logic [PH_W-1:0] en_ph(input logic [2:0] s);
    return (s == 3'h0) ? 2'h2 : 2'h1;
  endfunction : en_ph

  logic [PH_W-1:0] ph;
  logic            mc_last;

  xda_phase_gen #(
    .CLKS     (MC_CLKS)
  ) u_phase (
    .pclk     (pclk),
    .presetn  (presetn),
    .phase    (ph),
    .cyc_last (mc_last)
  );

  logic [2:0]  stretch_r;
  logic        wait_en_r;
  logic [15:0] dp0_r;
  logic [15:0] dp1_r;
  logic        dps_r;
  logic [7:0]  wreg_r;
  logic [7:0]  p2_r;
  logic        ta_step_r;
  logic [3:0]  ta_cnt_r;
  logic [3:0]  ta_cnt_nxt;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;
  logic        ck_touched_r;

  xda_state_t  state_r;
  xda_state_t  state_nxt;
  logic        pend_r;
  logic        dir_w_r;
  logic        mode_dp_r;
  logic [7:0]  wdat_r;
  logic [2:0]  s_r;
  logic [3:0]  rem_r;
  logic        first_r;
  logic        hold_r;
  logic        waited_r;
  logic [7:0]  mcnt_r;
  logic [7:0]  last_len_r;
  logic [7:0]  rdat_r;
  logic [15:0] addr_r;
  logic        rd_n_r;
  logic        wr_n_r;
  logic        oe_r;
  logic        done_r;

  // bus decode
  wire         setup    = psel & ~penable;
  wire         addr_ok  = hit(paddr, OFF_CLK_CTRL) | hit(paddr, OFF_MEM_MAP)
                        | hit(paddr, OFF_TA_KEY)   | hit(paddr, OFF_DPTR0)
                        | hit(paddr, OFF_DPTR1)    | hit(paddr, OFF_DP_SEL)
                        | hit(paddr, OFF_WORK_REG) | hit(paddr, OFF_PORT_TWO)
                        | hit(paddr, OFF_MOVE_CMD) | hit(paddr, OFF_STATUS);
  wire         wr_acc   = psel & penable & pwrite & pready_r & addr_ok;
  wire         ck_wr    = wr_acc & hit(paddr, OFF_CLK_CTRL);
  wire         mm_wr    = wr_acc & hit(paddr, OFF_MEM_MAP);
  wire         ta_wr    = wr_acc & hit(paddr, OFF_TA_KEY);
  wire         cmd_wr   = wr_acc & hit(paddr, OFF_MOVE_CMD);
  wire [7:0]   wbyte    = pwdata[7:0];
  wire         ta_open  = (ta_cnt_r != 4'h0);
  wire         idle     = (state_r == st_idle);
  wire         busy     = ~idle | pend_r;
  wire         go       = idle & pend_r & mc_last;

  wire [31:0]  stat_val = {7'h00, waited_r, last_len_r, rdat_r,
                           7'h00, busy};
  wire [31:0]  rd_val   =
      hit(paddr, OFF_CLK_CTRL) ? {29'h0000_0000, stretch_r} :
      hit(paddr, OFF_MEM_MAP)  ? {24'h00_0000, wait_en_r, 7'h00} :
      hit(paddr, OFF_DPTR0)    ? {16'h0000, dp0_r} :
      hit(paddr, OFF_DPTR1)    ? {16'h0000, dp1_r} :
      hit(paddr, OFF_DP_SEL)   ? {31'h0000_0000, dps_r} :
      hit(paddr, OFF_WORK_REG) ? {24'h00_0000, wreg_r} :
      hit(paddr, OFF_PORT_TWO) ? {24'h00_0000, p2_r} :
      hit(paddr, OFF_STATUS)   ? stat_val : WORD_RST;

  // zero wait state slave: ready rises in every access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= WORD_RST;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup & ~addr_ok;
      if (setup & ~pwrite) begin
        prdata_r <= rd_val;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stretch_r    <= STRETCH_RST;
      ck_touched_r <= 1'b0;
    end else if (ck_wr) begin
      stretch_r    <= pwdata[2:0];
      ck_touched_r <= 1'b1;
    end
  end

  // key pair opens a short window; one protected write closes it
  assign ta_cnt_nxt = ta_wr ? ((ta_step_r && wbyte == TA_KEY2) ?
                               TA_WIN_CLKS : 4'h0) :
                      mm_wr ? 4'h0 :
                      ta_open ? ta_cnt_r - 4'h1 : 4'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ta_step_r <= 1'b0;
      ta_cnt_r  <= 4'h0;
    end else begin
      ta_cnt_r  <= ta_cnt_nxt;
      if (ta_wr) begin
        ta_step_r <= (wbyte == TA_KEY1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_en_r <= WAIT_EN_RST;
    end else if (mm_wr && ta_open) begin
      wait_en_r <= pwdata[WAIT_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dp0_r  <= DATA_POINTER_RST;
      dp1_r  <= DATA_POINTER_RST;
      dps_r  <= 1'b0;
      wreg_r <= BYTE_RST;
      p2_r   <= BYTE_RST;
    end else begin
      if (wr_acc && hit(paddr, OFF_DPTR0))    dp0_r  <= pwdata[15:0];
      if (wr_acc && hit(paddr, OFF_DPTR1))    dp1_r  <= pwdata[15:0];
      if (wr_acc && hit(paddr, OFF_DP_SEL))   dps_r  <= pwdata[0];
      if (wr_acc && hit(paddr, OFF_WORK_REG)) wreg_r <= wbyte;
      if (wr_acc && hit(paddr, OFF_PORT_TWO)) p2_r   <= wbyte;
    end
  end

  // sequencer
  wire [15:0] dp_sel   = dps_r ? dp1_r : dp0_r;
  wire [15:0] addr_src = mode_dp_r ? dp_sel : {p2_r, wreg_r};
  wire        final_c  = (rem_r == 4'h0);
  // wait looked at in the final access cycle at zero stretch, otherwise in the access cycle before it
  wire        samp_cyc = (s_r == 3'h0) ? final_c : (rem_r == 4'h1);
  // zero stretch leaves the move length to the wait pin alone
  wire        samp_pt  = (state_r == st_access) & wait_en_r
                       & (ph == 2'h2) & samp_cyc;
  wire        strobe   = (state_r == st_access)
                       & (~first_r | (ph >= st_ph(s_r)))
                       & (~final_c | hold_r | (ph <= en_ph(s_r)));
  wire        end_move = (state_r == st_access) & mc_last
                       & final_c & ~hold_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      st_idle:   if (go) state_nxt = st_fetch;
      st_fetch:  if (mc_last) state_nxt = st_access;
      st_access: if (end_move) state_nxt = st_idle;
      default:   state_nxt = st_idle;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= st_idle;
    end else begin
      state_r <= state_nxt;
    end
  end

  // a command while a move is under way is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r    <= 1'b0;
      dir_w_r   <= 1'b0;
      mode_dp_r <= 1'b0;
      wdat_r    <= BYTE_RST;
    end else if (cmd_wr && !busy) begin
      pend_r    <= 1'b1;
      dir_w_r   <= pwdata[CMD_DIR_BIT];
      mode_dp_r <= pwdata[CMD_MODE_BIT];
      wdat_r    <= pwdata[CMD_DATA_LSB +: 8];
    end else if (go) begin
      pend_r    <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r     <= 3'h0;
      rem_r   <= 4'h0;
      first_r <= 1'b0;
      addr_r  <= DATA_POINTER_RST;
    end else if (go) begin
      s_r     <= stretch_r;
    end else if (state_r == st_fetch && mc_last) begin
      rem_r   <= {1'b0, s_r};
      first_r <= 1'b1;
      addr_r  <= addr_src;
    end else if (state_r == st_access && mc_last) begin
      first_r <= 1'b0;
      if (!hold_r && !final_c) begin
        rem_r <= rem_r - 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_r   <= 1'b0;
      waited_r <= 1'b0;
    end else begin
      if (samp_pt && !port_four_bit_zero_n) begin
        hold_r   <= 1'b1;
        waited_r <= 1'b1;
      end else if (mc_last) begin
        hold_r   <= 1'b0;
      end
      if (go) begin
        waited_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mcnt_r     <= 8'h00;
      last_len_r <= 8'h00;
      done_r     <= 1'b0;
    end else begin
      done_r <= end_move;
      if (go) begin
        mcnt_r <= 8'h00;
      end else if (!idle && mc_last && mcnt_r != 8'hFF) begin
        mcnt_r <= mcnt_r + 8'h01;
      end
      if (end_move) begin
        last_len_r <= (mcnt_r == 8'hFF) ? mcnt_r : mcnt_r + 8'h01;
      end
    end
  end

  // pins lag the internal strobe by one clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      oe_r   <= 1'b0;
      rdat_r <= BYTE_RST;
    end else begin
      rd_n_r <= ~(strobe & ~dir_w_r);
      wr_n_r <= ~(strobe & dir_w_r);
      oe_r   <= (state_nxt == st_access) & dir_w_r;
      if (!rd_n_r) begin
        rdat_r <= ext_rdata;
      end
    end
  end

  assign prdata      = prdata_r;
  assign pready      = pready_r;
  assign pslverr     = pslverr_r;
  assign ext_addr    = addr_r;
  assign ext_wdata   = wdat_r;
  assign ext_data_oe = oe_r;
  assign rd_n        = rd_n_r;
  assign wr_n        = wr_n_r;
  assign move_busy   = pend_r | ~(state_r == st_idle);
  assign move_done   = done_r;

  // checks
  wire       strb_pin = ~rd_n_r | ~wr_n_r;
  logic [7:0] sw_cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_cnt_r <= 8'h00;
    end else if (strb_pin) begin
      sw_cnt_r <= sw_cnt_r + 8'h01;
    end else begin
      sw_cnt_r <= 8'h00;
    end
  end
  wire [7:0] exp_w = (s_r == 3'h0) ? 8'h02 : {3'h0, s_r, 2'h0};

  property p_fetch_first;
    @(posedge pclk) disable iff (!presetn)
      go |=> (state_r == st_fetch) [*4] ##1 (state_r == st_access);
  endproperty
  a_fetch_first: assert property (p_fetch_first)
    else $error("move did not start with a four clock fetch");

  property p_strobe_width;
    @(posedge pclk) disable iff (!presetn)
      ($fell(strb_pin) && !waited_r) |-> (sw_cnt_r == exp_w);
  endproperty
  a_strobe_width: assert property (p_strobe_width)
    else $error("strobe width does not match stretch");

  property p_move_len;
    @(posedge pclk) disable iff (!presetn)
      (done_r && !waited_r) |-> (last_len_r == {5'h00, s_r} + 8'h02);
  endproperty
  a_move_len: assert property (p_move_len)
    else $error("move length is not stretch plus two");

  property p_quiet_idle;
    @(posedge pclk) disable iff (!presetn)
      (idle && $past(idle)) |-> (rd_n_r && wr_n_r && !hold_r);
  endproperty
  a_quiet_idle: assert property (p_quiet_idle)
    else $error("strobe outside an external move");

  property p_stretch_rst;
    @(posedge pclk) disable iff (!presetn)
      !ck_touched_r |-> (stretch_r == STRETCH_RST);
  endproperty
  a_stretch_rst: assert property (p_stretch_rst)
    else $error("stretch left its reset value unwritten");

  property p_wait_gated;
    @(posedge pclk) disable iff (!presetn)
      !wait_en_r |=> !hold_r;
  endproperty
  a_wait_gated: assert property (p_wait_gated)
    else $error("wait honoured while disabled");

  property p_min_len;
    @(posedge pclk) disable iff (!presetn)
      done_r |-> (last_len_r >= {5'h00, s_r} + 8'h02);
  endproperty
  a_min_len: assert property (p_min_len)
    else $error("move shorter than stretch minimum");

  property p_wait_sample;
    @(posedge pclk) disable iff (!presetn)
      (samp_pt && !port_four_bit_zero_n) |=> (hold_r && ph == 2'h3);
  endproperty
  a_wait_sample: assert property (p_wait_sample)
    else $error("asserted wait not recognised at state three");

  property p_wait_insert;
    @(posedge pclk) disable iff (!presetn)
      (mc_last && hold_r && state_r == st_access)
        |=> (state_r == st_access && $stable(rem_r));
  endproperty
  a_wait_insert: assert property (p_wait_insert)
    else $error("wait state cycle not inserted");

  property p_wait_end;
    @(posedge pclk) disable iff (!presetn)
      end_move |=> (idle && done_r);
  endproperty
  a_wait_end: assert property (p_wait_end)
    else $error("move did not end with wait released");

  property p_ta_guard;
    @(posedge pclk) disable iff (!presetn)
      (mm_wr && !ta_open) |=> $stable(wait_en_r);
  endproperty
  a_ta_guard: assert property (p_ta_guard)
    else $error("wait enable changed without timed access");

  property p_addr_src;
    @(posedge pclk) disable iff (!presetn)
      (state_r == st_fetch && mc_last) |=> (addr_r == $past(addr_src));
  endproperty
  a_addr_src: assert property (p_addr_src)
    else $error("external address not taken from its source");

  c_plain_read: cover property (@(posedge pclk) done_r && !dir_w_r);
  c_plain_write: cover property (@(posedge pclk) done_r && dir_w_r);
  c_waited: cover property (@(posedge pclk) done_r && waited_r);
  c_zero_wait: cover property (@(posedge pclk)
      done_r && waited_r && s_r == 3'h0);

endmodule : xda_ext_move

//--- bench/xda_mem_model.sv
`timescale 1ns/100ps
module xda_mem_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [15:0] ext_addr,
  input  wire logic [7:0]  ext_wdata,
  input  wire logic        ext_data_oe,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [7:0]  wait_clks,
  output logic      [7:0]  ext_rdata,
  output logic             wait_n,
  output logic      [15:0] wr_addr,
  output logic      [7:0]  wr_data
);
  logic [15:0] prev_addr_r;
  logic [7:0]  age_r;
  logic [7:0]  age;
  logic [7:0]  last_r;

  // clocks since the address last changed; upper half is the slow device
  assign age       = (ext_addr != prev_addr_r) ? 8'h00 : age_r;
  assign wait_n    = !(ext_addr[15] && (age < wait_clks));
  // a released bus shows the inverse of the last byte, never a stale copy
  assign ext_rdata = rd_n ? ~last_r : (ext_addr[7:0] ^ 8'h5A);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_addr_r <= 16'h0000;
      age_r       <= 8'h00;
      last_r      <= 8'h00;
      wr_addr     <= 16'h0000;
      wr_data     <= 8'h00;
    end else begin
      prev_addr_r <= ext_addr;
      age_r       <= (age == 8'hFF) ? age : age + 8'h01;
      if (!rd_n) last_r <= ext_rdata;
      // data only counts while the device really drives it
      if (!wr_n && ext_data_oe) begin
        wr_addr <= ext_addr;
        wr_data <= ext_wdata;
      end
    end
  end
endmodule : xda_mem_model

//--- bench/xda_ext_move_bench.sv
`timescale 1ns/100ps
module xda_ext_move_bench;
  import xda_pkg::*;
  logic              pclk;
  logic              presetn;
  logic [ADDR_W-1:0] paddr;
  logic              psel, penable, pwrite, pready, pslverr, errv;
  logic [31:0]       pwdata, prdata, rdv;
  logic [15:0]       ext_addr, wr_addr;
  logic [7:0]        ext_wdata, ext_rdata, wr_data, wait_clks;
  logic              ext_data_oe, rd_n, wr_n, wait_n, move_busy, move_done;
  int                fails, checked, width, i, s, k;

  xda_ext_move dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_data_oe(ext_data_oe),
    .ext_rdata(ext_rdata), .rd_n(rd_n), .wr_n(wr_n),
    .port_four_bit_zero_n(wait_n), .move_busy(move_busy),
    .move_done(move_done));

  xda_mem_model mem (.pclk(pclk), .presetn(presetn), .ext_addr(ext_addr),
    .ext_wdata(ext_wdata), .ext_data_oe(ext_data_oe), .rd_n(rd_n),
    .wr_n(wr_n), .wait_clks(wait_clks), .ext_rdata(ext_rdata),
    .wait_n(wait_n), .wr_addr(wr_addr), .wr_data(wr_data));

  initial begin
    pclk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) pclk = ~pclk;
  end

  task final_report;
    $display("counts: %0d checked, %0d fails", checked, fails);
    if (fails == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      fails++;
      $display("mismatch at %0t: no ready from slave", $time);
      final_report();
    end
    rdv  = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // runs one move; strobe width is only judged when exp_w is non-zero
  task move(input logic [31:0] cmd, input int exp_w);
    int n;
    width = 0;
    apb(1'b1, OFF_MOVE_CMD, cmd);
    for (n = 0; n < 400; n++) begin
      @(posedge pclk);
      if (n == 0) chk(move_busy, 1'b1, "busy after command");
      if (rd_n === 1'b0 || wr_n === 1'b0) width++;
      if (move_done === 1'b1) break;
    end
    if (n == 400) begin
      fails++;
      $display("mismatch at %0t: move never finished", $time);
      final_report();
    end
    if (exp_w > 0) chk(width, exp_w, "strobe clocks");
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk(rdv[0], 1'b0, "idle after move");
  endtask : move

  initial begin
    presetn   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = '0;
    pwdata    = 32'h0000_0000;
    wait_clks = 8'h08;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_CLK_CTRL, 32'h0000_0000);
    chk(rdv, {29'h0, STRETCH_RST}, "stretch reset");
    apb(1'b0, OFF_MEM_MAP, 32'h0000_0000);
    chk(rdv[7], WAIT_EN_RST, "wait enable reset");
    apb(1'b0, 12'h3FC, 32'h0000_0000);
    chk(errv, 1'b1, "unmapped error");
    $display("test reset values done");

    // slow device pulls wait low, but wait is still disabled
    apb(1'b1, OFF_DPTR0, 32'h0000_1234);
    apb(1'b1, OFF_DP_SEL, 32'h0000_0001);
    for (i = 1; i <= 8; i++) begin
      s = i % 8;
      if (s != 1) apb(1'b1, OFF_CLK_CTRL, s);
      apb(1'b1, OFF_DPTR1, 32'h0000_8010 + s);
      move(32'h0000_0002, (s == 0) ? 2 : 4 * s);
      chk(rdv[23:16], s + 2, "move cycles");
      chk(rdv[24], 1'b0, "wait ignored");
      chk(ext_addr, 16'h8010 + s, "pointer address");
      chk(rdv[15:8], (8'h10 + s) ^ 8'h5A, "read byte");
    end
    $display("test stretch sweep done");

    apb(1'b1, OFF_WORK_REG, 32'h0000_003C);
    apb(1'b1, OFF_PORT_TWO, 32'h0000_0021);
    move(32'h0000_C701, 2);
    chk(wr_addr, 16'h213C, "indexed address");
    chk(wr_data, 8'hC7, "write byte");
    $display("test indexed write done");

    apb(1'b1, OFF_MEM_MAP, 32'h0000_0080);
    apb(1'b0, OFF_MEM_MAP, 32'h0000_0000);
    chk(rdv[7], 1'b0, "plain write blocked");
    apb(1'b1, OFF_TA_KEY, {24'h0, TA_KEY1});
    apb(1'b1, OFF_TA_KEY, {24'h0, TA_KEY2});
    apb(1'b1, OFF_MEM_MAP, 32'h0000_0080);
    apb(1'b1, OFF_MEM_MAP, 32'h0000_0000);
    apb(1'b0, OFF_MEM_MAP, 32'h0000_0000);
    chk(rdv[7], 1'b1, "window used once");
    $display("test timed access done");

    // wait held low long enough for k samples at stretch 0
    for (k = 0; k < 4; k++) begin
      wait_clks <= 4 * k;
      apb(1'b1, OFF_DPTR1, 32'h0000_8040 + k);
      move(32'h0000_0002, (k == 0) ? 2 : 0);
      chk(rdv[23:16], k + 2, "cycles with wait");
      chk(rdv[24], k != 0, "wait seen");
    end
    apb(1'b1, OFF_CLK_CTRL, 32'h0000_0002);
    wait_clks <= 8'h08;
    apb(1'b1, OFF_DPTR1, 32'h0000_8050);
    move(32'h0000_0002, 0);
    chk(rdv[23:16], 5, "stretch plus wait");
    wait_clks <= 8'h00;
    apb(1'b1, OFF_DPTR1, 32'h0000_8051);
    move(32'h0000_0002, 8);
    chk(rdv[23:16], 4, "stretch is minimum");
    $display("test wait states done");
    final_report();
  end
endmodule : xda_ext_move_bench
